// file: verilog/tsc_control.sv
`timescale 1ns/10ps
module tsc_control #(
  parameter int DW = tsc_pkg::DATA_W,
  parameter int AW = tsc_pkg::ADDR_W
) (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          host_cs_n,
  input  wire logic          host_wr_n,
  input  wire logic [AW-1:0] host_addr,
  input  wire logic [DW-1:0] host_wdata,
  output logic      [DW-1:0] host_rdata,
  output logic               host_rvalid,
  input  wire logic [5:0]    input_delay_code,
  input  wire logic          clock_in_8m,
  input  wire logic          frame_pulse_in,
  output logic               filter_active,
  output logic               filter_high_jitter,
  output logic               filter_mode_reserved,
  output logic               sample_point_select,
  output logic [1:0]         sample_point,
  output logic [2:0]         whole_bit_delay,
  output logic [4:0]         quarter_bit_delay,
  output logic               frame_width_error,
  output logic               frame_boundary,
  output logic               frame_pulse_out_8m,
  output logic               frame_pulse_out_16m,
  output logic               clock_out_8m,
  output logic               clock_out_16m
);
  // ==========================================================================
  // Control word
  logic [DW-1:0] switch_control_word;
  logic          ctrl_hit;
  logic          boundary_filter_enable;
  logic [2:0]    boundary_filter_mode;
  logic          frame_pulse_width_select;
  logic          input_clock_edge_select;
  logic          output_clock_invert;

  assign ctrl_hit = !host_cs_n && !host_addr[tsc_pkg::REG_SEL_BIT]
                    && (host_addr[13:0] == tsc_pkg::CTRL_WORD_OFFSET);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_control_word <= tsc_pkg::CTRL_WORD_RESET;
    end else if (ctrl_hit && !host_wr_n) begin
      // Reserved bits held at zero whatever software writes
      switch_control_word <= host_wdata & tsc_pkg::CTRL_WORD_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rdata  <= '0;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= !host_cs_n && host_wr_n;
      host_rdata  <= (ctrl_hit && host_wr_n) ? switch_control_word : '0;
    end
  end

  assign boundary_filter_mode     =
    switch_control_word[tsc_pkg::FILTER_MODE_HI:tsc_pkg::FILTER_MODE_LO];
  assign boundary_filter_enable   = switch_control_word[tsc_pkg::FILTER_EN_BIT];
  assign frame_pulse_width_select = switch_control_word[tsc_pkg::PULSE_WIDTH_BIT];
  assign input_clock_edge_select  = switch_control_word[tsc_pkg::IN_EDGE_BIT];
  assign output_clock_invert      = switch_control_word[tsc_pkg::OUT_INV_BIT];

  // ==========================================================================
  // Boundary filter settings
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      filter_active        <= 1'b0;
      filter_high_jitter   <= 1'b0;
      filter_mode_reserved <= 1'b0;
    end else begin
      filter_active        <= boundary_filter_enable;
      filter_high_jitter   <= boundary_filter_enable
                              && (boundary_filter_mode == tsc_pkg::FILTER_MODE_BOTH);
      filter_mode_reserved <= boundary_filter_enable
                              && (boundary_filter_mode != tsc_pkg::FILTER_MODE_BOTH)
                              && (boundary_filter_mode != tsc_pkg::FILTER_MODE_LOW);
    end
  end

  // ==========================================================================
  // Input sampling point and delay
  tsc_pkg::tsc_sample_t next_sample_point;

  always_comb begin
    if (switch_control_word[tsc_pkg::SAMPLE_SEL_BIT]) begin
      next_sample_point = tsc_pkg::tsc_sample_t'(input_delay_code[1:0]);
    end else begin
      next_sample_point = tsc_pkg::TSC_SAMPLE_3Q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_point_select <= 1'b0;
      sample_point        <= 2'h0;
      whole_bit_delay     <= 3'h0;
      quarter_bit_delay   <= 5'h00;
    end else begin
      sample_point_select <= switch_control_word[tsc_pkg::SAMPLE_SEL_BIT];
      sample_point        <= next_sample_point;
      if (switch_control_word[tsc_pkg::SAMPLE_SEL_BIT]) begin
        whole_bit_delay   <= input_delay_code[4:2];
        quarter_bit_delay <= {input_delay_code[4:2], 2'h0};
      end else begin
        whole_bit_delay   <= input_delay_code[4:2];
        quarter_bit_delay <= input_delay_code[4:0];
      end
    end
  end

  // ==========================================================================
  // Frame boundary detection on the selected input clock edge
  logic clk_prev;
  logic fp_prev;
  logic edge_seen;
  logic [tsc_pkg::PW_W-1:0] fp_len;
  logic [tsc_pkg::PW_W-1:0] expect_len;
  logic                     edge_armed;

  // Least samples a full-width input pulse shows at this clock
  localparam logic [tsc_pkg::PW_W-1:0] MIN_NARROW_CYC =
    tsc_pkg::PW_W'(tsc_pkg::PULSE_NARROW_NS / tsc_pkg::CLK_PERIOD_NS);
  localparam logic [tsc_pkg::PW_W-1:0] MIN_WIDE_CYC   =
    tsc_pkg::PW_W'(tsc_pkg::PULSE_WIDE_NS / tsc_pkg::CLK_PERIOD_NS);

  assign edge_seen = edge_armed
                     && (input_clock_edge_select ? (clock_in_8m && !clk_prev)
                                                 : (!clock_in_8m && clk_prev));
  assign expect_len = frame_pulse_width_select ? MIN_WIDE_CYC : MIN_NARROW_CYC;

  // Edge detector armed once a true previous clock sample exists
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_armed <= 1'b0;
    end else begin
      edge_armed <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev       <= 1'b0;
      fp_prev        <= 1'b0;
      fp_len         <= '0;
      frame_boundary <= 1'b0;
    end else begin
      clk_prev       <= clock_in_8m;
      fp_prev        <= frame_pulse_in;
      frame_boundary <= edge_seen && frame_pulse_in && !fp_prev;
      if (frame_pulse_in) begin
        fp_len <= (fp_len == '1) ? fp_len : fp_len + tsc_pkg::PW_W'(1);
      end else begin
        fp_len <= '0;
      end
    end
  end

  // Input pulse shorter than the selected width is flagged
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_width_error <= 1'b0;
    end else if (fp_prev && !frame_pulse_in) begin
      frame_width_error <= (fp_len < expect_len);
    end
  end

  // ==========================================================================
  // Output frame pulses
  logic [tsc_pkg::PW_W-1:0] len_8m;
  logic [tsc_pkg::PW_W-1:0] len_16m;

  assign len_8m  = frame_pulse_width_select ? tsc_pkg::PULSE_WIDE_CYC
                                            : tsc_pkg::PULSE_NARROW_CYC;
  assign len_16m = frame_pulse_width_select ? tsc_pkg::PULSE_NARROW_CYC
                                            : tsc_pkg::PULSE_HALF_CYC;

  tsc_pulse_gen #(.W(tsc_pkg::PW_W)) u_pulse_8m (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (frame_boundary),
    .length   (len_8m),
    .pulse    (frame_pulse_out_8m)
  );

  tsc_pulse_gen #(.W(tsc_pkg::PW_W)) u_pulse_16m (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (frame_boundary),
    .length   (len_16m),
    .pulse    (frame_pulse_out_16m)
  );

  // ==========================================================================
  // Output clocks
  logic clk16_div;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk16_div     <= 1'b0;
      clock_out_8m  <= 1'b0;
      clock_out_16m <= 1'b0;
    end else begin
      clk16_div     <= !clk16_div;
      clock_out_8m  <= clock_in_8m ^ output_clock_invert;
      clock_out_16m <= clk16_div ^ output_clock_invert;
    end
  end
endmodule // tsc_control

// file: verilog/tsc_pkg.sv
package tsc_pkg;
  // ==========================================================================
  // Host port
  localparam int          ADDR_W              = 15;
  localparam int          DATA_W              = 16;
  localparam int          REG_SEL_BIT         = 14;
  localparam logic [13:0] CTRL_WORD_OFFSET    = 14'h0000;
  localparam logic [15:0] CTRL_WORD_RESET     = 16'h0000;
  // Defined, writable fields of the control word (bits 15:5 less reserved)
  localparam logic [15:0] CTRL_WORD_MASK      = 16'hF560;
  // ==========================================================================
  // Field positions
  localparam int          FILTER_MODE_HI      = 15;
  localparam int          FILTER_MODE_LO      = 13;
  localparam int          SAMPLE_SEL_BIT      = 12;
  localparam int          FILTER_EN_BIT       = 10;
  localparam int          PULSE_WIDTH_BIT     = 8;
  localparam int          IN_EDGE_BIT         = 6;
  localparam int          OUT_INV_BIT         = 5;
  // ==========================================================================
  // Filter mode codes
  localparam logic [2:0]  FILTER_MODE_LOW     = 3'h0;
  localparam logic [2:0]  FILTER_MODE_BOTH    = 3'h7;
  // ==========================================================================
  // Frame pulse widths
  localparam int          CLK_PERIOD_NS       = 40;
  localparam int          PULSE_NARROW_NS     = 122;
  localparam int          PULSE_WIDE_NS       = 244;
  localparam int          PULSE_HALF_NS       = 61;
  localparam int          PW_W                = 4;
  // Least times round up
  localparam logic [3:0]  PULSE_NARROW_CYC    =
    4'((PULSE_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  PULSE_WIDE_CYC      =
    4'((PULSE_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  PULSE_HALF_CYC      =
    4'((PULSE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ==========================================================================
  // Sample points
  typedef enum logic [1:0] {
    TSC_SAMPLE_3Q,
    TSC_SAMPLE_4Q,
    TSC_SAMPLE_1Q,
    TSC_SAMPLE_2Q
  } tsc_sample_t;
endpackage

// file: verilog/tsc_pulse_gen.sv
`timescale 1ns/10ps
// ============================================================================
// Stretches a one-cycle start into a pulse of a given length
module tsc_pulse_gen #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         start,
  input  wire logic [W-1:0] length,
  output logic              pulse
);
  logic [W-1:0] remaining;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= '0;
      pulse     <= 1'b0;
    end else if (start) begin
      remaining <= length - W'(1);
      pulse     <= (length != '0);
    end else if (remaining != '0) begin
      remaining <= remaining - W'(1);
      pulse     <= 1'b1;
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule // tsc_pulse_gen

// file: dv/tsc_control_sva.sv
`timescale 1ns/10ps
// ==========================================================================
// Port checker
module tsc_control_sva (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        host_cs_n,
  input wire logic        host_wr_n,
  input wire logic [14:0] host_addr,
  input wire logic [15:0] host_rdata,
  input wire logic        host_rvalid,
  input wire logic        filter_active,
  input wire logic        filter_high_jitter,
  input wire logic        filter_mode_reserved,
  input wire logic        sample_point_select,
  input wire logic [1:0]  sample_point,
  input wire logic        frame_boundary,
  input wire logic        frame_pulse_out_8m,
  input wire logic        frame_pulse_out_16m
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_read; !host_cs_n && host_wr_n; endsequence
  sequence s_pulses; frame_pulse_out_8m && frame_pulse_out_16m; endsequence
  a_read_answer: assert property (s_read |=> host_rvalid)
    else $error("read not answered");
  a_idle_quiet: assert property ((host_cs_n || !host_wr_n) |=> !host_rvalid)
    else $error("answer without read");
  a_rsv_zero: assert property (host_rvalid |-> (host_rdata & 16'h0A9F) == 16'h0000)
    else $error("undefined bits read high");
  a_unmapped_zero: assert property (s_read ##0 (host_addr[14] ||
    host_addr[13:0] != 14'h0000) |=> host_rdata == 16'h0000) else $error("unmapped read");
  a_filter_gate: assert property (!filter_active |->
    !filter_high_jitter && !filter_mode_reserved) else $error("filter mode not ignored");
  a_sample_fixed: assert property (!sample_point_select && $past(!sample_point_select)
    |-> sample_point == 2'h0) else $error("sample point moved");
  a_boundary_pulse: assert property (frame_boundary |=> s_pulses)
    else $error("no pulses after boundary");
  a_fp8_min: assert property ($rose(frame_pulse_out_8m) |-> frame_pulse_out_8m[*4])
    else $error("8m pulse short");
  a_fp8_end: assert property ($rose(frame_pulse_out_8m) |-> ##[4:7] !frame_pulse_out_8m)
    else $error("8m pulse long");
  a_fp16_min: assert property ($rose(frame_pulse_out_16m) |-> frame_pulse_out_16m[*2])
    else $error("16m pulse short");
endmodule // tsc_control_sva
bind tsc_control tsc_control_sva u_sva (.core_clk, .reset_n, .host_cs_n, .host_wr_n,
  .host_addr, .host_rdata, .host_rvalid, .filter_active, .filter_high_jitter,
  .filter_mode_reserved, .sample_point_select, .sample_point, .frame_boundary,
  .frame_pulse_out_8m, .frame_pulse_out_16m);

// file: dv/tsc_frame_src.sv
`timescale 1ns/10ps
// ==========================================================================
// Frame source: free 8 MHz clock, frame pulse on a chosen edge
module tsc_frame_src (
  input  wire logic fire,
  input  wire logic rise,
  input  wire logic wide,
  output logic      clock_in_8m,
  output logic      frame_pulse_in
);
  initial begin
    clock_in_8m = 1'b1;
    frame_pulse_in = 1'b0;
    #7;
    forever #62.5 clock_in_8m = ~clock_in_8m;
  end
  always @(posedge fire) begin
    if (rise) @(posedge clock_in_8m);
    else @(negedge clock_in_8m);
    frame_pulse_in = 1'b1;
    #(wide ? 244 : 122);
    frame_pulse_in = 1'b0;
  end
endmodule // tsc_frame_src

// file: dv/tsc_control_bench.sv
`timescale 1ns/10ps
module tsc_control_bench;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        host_cs_n = 1'b1;
  logic        host_wr_n = 1'b1;
  logic [14:0] host_addr = 15'h0000;
  logic [15:0] host_wdata = 16'h0000;
  logic [5:0]  input_delay_code = 6'h00;
  logic        fire = 1'b0;
  logic        rise = 1'b0;
  logic        wide = 1'b0;
  logic        ci_q, c16;
  logic [15:0] host_rdata;
  logic [1:0]  sample_point;
  logic [2:0]  whole_bit_delay;
  logic [4:0]  quarter_bit_delay;
  logic        host_rvalid, filter_active, filter_high_jitter, filter_mode_reserved;
  logic        sample_point_select, frame_boundary, frame_pulse_out_8m;
  logic        frame_pulse_out_16m, clock_out_8m, clock_out_16m;
  logic        clock_in_8m, frame_pulse_in;
  logic        frame_width_error;
  logic        ph = 1'b0;
  int          errors = 0;
  int          n_checks = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) ci_q <= clock_in_8m;
  always @(posedge core_clk) begin
    if (reset_n) ph <= !ph;
  end
  tsc_frame_src src (.fire, .rise, .wide, .clock_in_8m, .frame_pulse_in);
  tsc_control dut (.core_clk, .reset_n, .host_cs_n, .host_wr_n, .host_addr, .host_wdata,
    .host_rdata, .host_rvalid, .input_delay_code, .clock_in_8m, .frame_pulse_in,
    .filter_active, .filter_high_jitter, .filter_mode_reserved, .sample_point_select,
    .sample_point, .whole_bit_delay, .quarter_bit_delay, .frame_width_error,
    .frame_boundary, .frame_pulse_out_8m, .frame_pulse_out_16m, .clock_out_8m,
    .clock_out_16m);
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [14:0] a, logic [15:0] d);
    @(negedge core_clk);
    host_cs_n = 1'b0;
    host_wr_n = !w;
    host_addr = a;
    host_wdata = d;
    @(negedge core_clk);
    host_cs_n = 1'b1;
  endtask
  task automatic rd(logic [14:0] a, logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk("rvalid", 16'(host_rvalid), 16'h0001);
    chk("rdata", host_rdata, e);
  endtask
  task automatic setw(logic [15:0] d);
    acc(1'b1, 15'h0000, d);
    repeat (2) @(negedge core_clk);
  endtask
  task automatic frame(logic e, logic w, logic hit, logic sw);
    int t, n8, n16;
    t = 0;
    n8 = 0;
    n16 = 0;
    rise = e;
    wide = sw;
    fire = 1'b1;
    repeat (24) begin
      @(negedge core_clk);
      fire = 1'b0;
      t += frame_boundary;
      n8 += frame_pulse_out_8m;
      n16 += frame_pulse_out_16m;
    end
    chk("boundary", 16'(t), 16'(hit));
    chk("fp8", 16'(n8), !hit ? 16'h0000 : w ? 16'(tsc_pkg::PULSE_WIDE_CYC)
      : 16'(tsc_pkg::PULSE_NARROW_CYC));
    chk("fp16", 16'(n16), !hit ? 16'h0000 : w ? 16'(tsc_pkg::PULSE_NARROW_CYC)
      : 16'(tsc_pkg::PULSE_HALF_CYC));
    chk("fpw", 16'(frame_width_error), 16'(w && !sw));
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    rd(15'h0000, 16'h0000);
    acc(1'b1, 15'h0000, 16'hFFFF);
    rd(15'h0000, 16'hF560);
    acc(1'b1, 15'h4000, 16'h0000);
    rd(15'h0000, 16'hF560);
    rd(15'h4000, 16'h0000);
    rd(15'h0001, 16'h0000);
    $display("test host done");
    for (int m = 0; m < 8; m++) begin
      setw({3'(m), 13'h0400});
      chk("en", 16'(filter_active), 16'h0001);
      chk("hi", 16'(filter_high_jitter), 16'(m == 7));
      chk("rsv", 16'(filter_mode_reserved), 16'(m != 0 && m != 7));
      setw({3'(m), 13'h0000});
      chk("off", 16'({filter_active, filter_high_jitter, filter_mode_reserved}), 16'h0000);
    end
    $display("test filter done");
    input_delay_code = 6'h1B;
    setw(16'h0000);
    chk("pt", 16'(sample_point), 16'h0000);
    chk("qd", 16'(quarter_bit_delay), 16'h001B);
    setw(16'h1000);
    chk("pt", 16'(sample_point), 16'h0003);
    chk("wd", 16'(whole_bit_delay), 16'h0006);
    chk("qd", 16'(quarter_bit_delay), 16'h0018);
    $display("test sample done");
    for (int v = 0; v < 2; v++) begin
      setw(v[0] ? 16'h0020 : 16'h0000);
      repeat (6) begin
        c16 = clock_out_16m;
        @(negedge core_clk);
        chk("c8", 16'(clock_out_8m), 16'(ci_q ^ v[0]));
        chk("c16", 16'(clock_out_16m), 16'(!c16));
        chk("c16p", 16'(clock_out_16m), 16'(!ph ^ v[0]));
      end
    end
    $display("test clock done");
    for (int f = 0; f < 4; f++) begin
      setw({7'h00, f[1], 1'b0, f[0], 6'h00});
      frame(!f[0], f[1], 1'b0, !f[1]);
      frame(f[0], f[1], 1'b1, f[1]);
    end
    $display("test frame done");
    finish_test();
  end
endmodule // tsc_control_bench
